// >>> pkg/rpm_pkg.sv
package rpm_pkg;

   // ---------------------------------------------------------------
   // Machine cycle timing
   // ---------------------------------------------------------------
   localparam int unsigned OSC_PER_MC     = 12;
   localparam logic [3:0]  MC_LAST_IDX    = 4'hB;
   localparam logic [3:0]  S5P2_IDX       = 4'h9;
   localparam logic [4:0]  RST_TAKE_DELAY = 5'h13;   // 19 osc periods
   localparam logic [11:0] ALE_HIGH_MASK  = 12'h186; // S1P2-S2P1, S4P2-S5P1
   localparam logic [11:0] FETCH_LO_MASK  = 12'hC30; // S3 and S6

   // ---------------------------------------------------------------
   // Register map (index times four is the byte address)
   // ---------------------------------------------------------------
   localparam int          AHB_DW        = 32;
   localparam logic [7:0]  PMC_INDEX     = 8'h87;
   localparam logic [7:0]  STATUS_INDEX  = 8'h88;
   localparam logic [31:0] PMC_ADDR      = {22'h0, PMC_INDEX, 2'h0};
   localparam logic [31:0] STATUS_ADDR   = {22'h0, STATUS_INDEX, 2'h0};
   localparam logic [2:0]  SIZE_WORD     = 3'h2;
   localparam logic [7:0]  PMC_RESET     = 8'h00;
   localparam logic [7:0]  PMC_WMASK_EXT = 8'hEF;
   localparam logic [7:0]  PMC_WMASK_BAS = 8'h8F;

   // power_mode_control bit positions
   localparam int SLEEP_CPU_BIT  = 0;
   localparam int OSC_STOP_BIT   = 1;
   localparam int USER_FLAG_0    = 2;
   localparam int USER_FLAG_1    = 3;
   localparam int WAKE_ANY_BIT   = 5;
   localparam int PIN_SHUT_EN    = 6;
   localparam int BAUD_DOUBLE    = 7;

   // ---------------------------------------------------------------
   // State encodings
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      MODE_RUN, MODE_IDLE, MODE_PDOWN
   } rpm_mode_type;

   typedef enum logic [1:0] {
      RSEQ_NORMAL, RSEQ_PEND, RSEQ_ACTIVE, RSEQ_RELEASE
   } rpm_rseq_type;

endpackage : rpm_pkg

// >>> design/rpm_mcycle.sv
`timescale 1ns/1ps
module rpm_mcycle (
   input  wire logic       clk_i,
   input  wire logic       arst_n_i,
   input  wire logic       rst_pin_i,
   output logic [3:0]      idx_o,
   output logic            s5p2_o,
   output logic            rst_smp_o
);
   import rpm_pkg::*;

   typedef struct packed {
      logic [3:0] idx;
      logic       s5p2;
      logic       smp;
   } rpm_mc_type;

   rpm_mc_type q, d;

   // ---------------------------------------------------------------
   // Twelve periods: six states of two phases each
   // ---------------------------------------------------------------
   always_comb begin
      d      = q;
      d.idx  = (q.idx == MC_LAST_IDX) ? 4'h0 : q.idx + 4'h1;
      d.s5p2 = (q.idx == S5P2_IDX);
      // Pin is looked at once per cycle only, so short glitches vanish
      if (q.idx == S5P2_IDX) begin
         d.smp = rst_pin_i;
      end
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign idx_o     = q.idx;
   assign s5p2_o    = q.s5p2;
   assign rst_smp_o = q.smp;

endmodule : rpm_mcycle

// >>> design/rpm_top.sv
// Overview of operation
// - Reset pin is sampled once per machine cycle at state 5 phase 2.
// - Internal reset takes hold 19 periods after a high sample.
// - While reset pin is high both bus strobes are only weakly pulled.
// - Strobes restart one to two machine cycles after reset pin falls.
// - Reset zeroes control registers; ports go all-ones.
// - Reset leaves internal data memory untouched.
// - Ports go all-ones as soon as reset pin is high.
// - Idle stops only the core clock; peripherals and oscillator run.
// - Bit 0 selects idle, bit 1 power-down, in the control register.
// - Idle keeps core state and port data, strobes held high.
// - Enabled request clears the idle bit and wakes with service.
// - Reset ends idle and reinitialises registers, not memory.
// - With wake-any set, any request ends idle.
// - Without requests only reset ends idle.
// - Power-down stops the oscillator and drives both strobes low.
// - Basic variant leaves power-down only through reset.
// - Extended variant runs timers in power-down on counter input clocks.
// - Two user flag bits are plain read-write storage.
// - After a service return one more instruction runs first.
// - Pin shutdown: falling counter b edge arms, instruction end enters, rising edge exits.
// - Enabled wake vectors to service; disabled wake-any resumes.
//
// Added by the designer: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module rpm_top #(
   parameter bit EXTENDED = 1'b1,
   parameter int NUM_SRC  = 6
) (
   input  wire logic                        CLK_I,
   input  wire logic                        ARST_N_I,
   input  wire logic                        HSEL_I,
   input  wire logic [rpm_pkg::AHB_DW-1:0]  HADDR_I,
   input  wire logic [1:0]                  HTRANS_I,
   input  wire logic                        HWRITE_I,
   input  wire logic [2:0]                  HSIZE_I,
   input  wire logic [rpm_pkg::AHB_DW-1:0]  HWDATA_I,
   input  wire logic                        HREADY_I,
   output logic      [rpm_pkg::AHB_DW-1:0]  HRDATA_O,
   output logic                             HREADYOUT_O,
   output logic                             HRESP_O,
   input  wire logic                        RST_PIN_I,
   input  wire logic [NUM_SRC-1:0]          INT_REQ_I,
   input  wire logic [NUM_SRC-1:0]          INT_EN_I,
   input  wire logic                        COUNTER_A_I,
   input  wire logic                        COUNTER_B_I,
   input  wire logic                        INSTR_END_I,
   input  wire logic                        RETURN_FROM_SERVICE_OP_DONE_I,
   output logic                             ADDR_LATCH_O,
   output logic                             ADDR_LATCH_OE_O,
   output logic                             PROG_FETCH_STROBE_N_O,
   output logic                             PROG_FETCH_OE_O,
   output logic                             PORT_ONES_O,
   output logic                             SFR_RESET_O,
   output logic                             CPU_CLK_EN_O,
   output logic                             OSC_RUN_O,
   output logic                             PERIPH_CLK_EN_O,
   output logic                             WAKE_O,
   output logic                             WAKE_VECTOR_O,
   output logic                             BAUD_DOUBLE_O,
   output logic                             INT_ACCEPT_OK_O
);
   import rpm_pkg::*;

   localparam logic [7:0] PMC_WMASK = EXTENDED ? PMC_WMASK_EXT
                                               : PMC_WMASK_BAS;

   // ---------------------------------------------------------------
   // State of the whole block
   // ---------------------------------------------------------------
   typedef struct packed {
      rpm_rseq_type rseq;
      rpm_mode_type mode;
      logic [4:0]   dly;
      logic [7:0]   pmc;
      logic         pin;
      logic         ca;
      logic         cb;
      logic         hw_pend;
      logic         hw_pd;
      logic         sw_pd;
      logic         rise_seen;
      logic         int_seen;
      logic         return_from_service_op_block;
      logic         acc_ok;
      logic         ph_valid;
      logic         ph_write;
      logic         ph_pmc;
      logic         hready;
      logic [31:0]  rdata;
      logic         ale;
      logic         ale_oe;
      logic         fetch_n;
      logic         fetch_oe;
      logic         port_ones;
      logic         sfr_rst;
      logic         cpu_en;
      logic         osc_run;
      logic         periph_en;
      logic         wake;
      logic         wake_vec;
   } rpm_state_type;

   rpm_state_type q, d;

   logic [3:0] mc_idx;
   logic       mc_s5p2;
   logic       rst_smp;

   // Cycle generator and reset pin sampler
   rpm_mcycle u_mcycle (
      .clk_i     (CLK_I),
      .arst_n_i  (ARST_N_I),
      .rst_pin_i (RST_PIN_I),
      .idx_o     (mc_idx),
      .s5p2_o    (mc_s5p2),
      .rst_smp_o (rst_smp)
   );

   // ---------------------------------------------------------------
   // Request decode
   // ---------------------------------------------------------------
   logic req_en;
   logic req_any;
   logic int_wake;
   logic cb_fall;
   logic cb_rise;
   logic bus_take;
   logic [31:0] status;

   // Wake term folds the wake-any bit in; basic parts never see it set
   always_comb begin
      req_en   = |(INT_REQ_I & INT_EN_I);
      req_any  = |INT_REQ_I;
      int_wake = req_en | (q.pmc[WAKE_ANY_BIT] & req_any);
      cb_fall  = q.cb & ~COUNTER_B_I;
      cb_rise  = ~q.cb & COUNTER_B_I;
      bus_take = HSEL_I & HTRANS_I[1] & HREADY_I & (HSIZE_I == SIZE_WORD);
      status   = {24'h0, q.wake_vec, q.return_from_service_op_block, q.sw_pd, q.hw_pd,
                  q.hw_pend, (q.rseq == RSEQ_ACTIVE), q.mode};
   end

   // ---------------------------------------------------------------
   // Next state
   // ---------------------------------------------------------------
   always_comb begin
      d      = q;
      d.pin  = RST_PIN_I;
      d.ca   = COUNTER_A_I;
      d.cb   = COUNTER_B_I;
      d.wake = 1'b0;

      // Reset sequence driven by the once-per-cycle sample
      case (q.rseq)
         RSEQ_NORMAL: begin
            if (mc_s5p2 && rst_smp) begin
               d.rseq = RSEQ_PEND;
               d.dly  = RST_TAKE_DELAY - 5'h1;
            end
         end
         RSEQ_PEND: begin
            // Internal reset waits until the count expires
            if (q.dly == 5'h0) begin
               d.rseq = RSEQ_ACTIVE;
            end else begin
               d.dly = q.dly - 5'h1;
            end
         end
         RSEQ_ACTIVE: begin
            if (mc_s5p2 && !rst_smp) begin
               d.rseq = RSEQ_RELEASE;
            end
         end
         RSEQ_RELEASE: begin
            // One more cycle boundary before strobes run again
            if (mc_s5p2) begin
               d.rseq = rst_smp ? RSEQ_ACTIVE : RSEQ_NORMAL;
            end
         end
         default: begin
            d.rseq = RSEQ_NORMAL;
         end
      endcase

      // Service return blocks acceptance for one more instruction
      if (RETURN_FROM_SERVICE_OP_DONE_I) begin
         d.return_from_service_op_block = 1'b1;
      end else if (INSTR_END_I) begin
         d.return_from_service_op_block = 1'b0;
      end

      // Power mode machine
      case (q.mode)
         MODE_RUN: begin
            if (EXTENDED && q.pmc[PIN_SHUT_EN] && cb_fall) begin
               d.hw_pend = 1'b1;
            end
            if (q.pmc[OSC_STOP_BIT]) begin
               d.mode      = MODE_PDOWN;
               d.sw_pd     = 1'b1;
               d.hw_pd     = d.hw_pend;
               d.hw_pend   = 1'b0;
               d.rise_seen = 1'b0;
               d.int_seen  = 1'b0;
            end else if (d.hw_pend && INSTR_END_I) begin
               d.mode      = MODE_PDOWN;
               d.hw_pd     = 1'b1;
               d.sw_pd     = 1'b0;
               d.hw_pend   = 1'b0;
               d.rise_seen = 1'b0;
               d.int_seen  = 1'b0;
            end else if (q.pmc[SLEEP_CPU_BIT]) begin
               d.mode = MODE_IDLE;
            end
         end
         MODE_IDLE: begin
            // Nothing but a request or reset leaves idle
            if (int_wake) begin
               d.mode               = MODE_RUN;
               d.pmc[SLEEP_CPU_BIT] = 1'b0;
               d.wake               = 1'b1;
               d.wake_vec           = req_en;
            end
         end
         MODE_PDOWN: begin
            d.rise_seen = q.rise_seen | cb_rise;
            d.int_seen  = q.int_seen | (EXTENDED & int_wake);
            if ((!q.hw_pd || d.rise_seen) && (!q.sw_pd || d.int_seen)) begin
               d.mode              = MODE_RUN;
               d.pmc[OSC_STOP_BIT] = 1'b0;
               d.hw_pd             = 1'b0;
               d.sw_pd             = 1'b0;
               d.wake              = 1'b1;
               d.wake_vec          = q.sw_pd & req_en;
            end
         end
         default: begin
            d.mode = MODE_RUN;
         end
      endcase

      // AHB-Lite slave: every word transfer takes one wait state
      d.hready = 1'b1;
      if (q.ph_valid) begin
         d.ph_valid = 1'b0;
         if (q.ph_write && q.ph_pmc) begin
            // Software write last so a set beats a hardware clear
            d.pmc = (d.pmc & ~PMC_WMASK)
                    | (HWDATA_I[7:0] & PMC_WMASK);
         end
      end else if (bus_take) begin
         d.ph_valid = 1'b1;
         d.ph_write = HWRITE_I;
         d.ph_pmc   = (HADDR_I == PMC_ADDR);
         d.hready   = 1'b0;
         if (HADDR_I == PMC_ADDR) begin
            d.rdata = {24'h0, q.pmc};
         end else if (HADDR_I == STATUS_ADDR) begin
            d.rdata = status;
         end else begin
            d.rdata = 32'h0000_0000;
         end
      end

      // Internal reset overrides the control register, mode and wake flags; data memory has no reset
      if (q.rseq == RSEQ_ACTIVE) begin
         d.pmc       = PMC_RESET;
         d.mode      = MODE_RUN;
         d.hw_pend   = 1'b0;
         d.hw_pd     = 1'b0;
         d.sw_pd     = 1'b0;
         d.wake      = 1'b0;
         d.wake_vec  = 1'b0;
         d.return_from_service_op_block = 1'b0;
      end

      // Output images, registered straight onto the pins
      d.port_ones = d.pin | (d.rseq == RSEQ_ACTIVE);
      // Lags the sequence by a cycle so it still stands as it ends
      d.sfr_rst   = (q.rseq == RSEQ_ACTIVE);
      d.acc_ok    = ~d.return_from_service_op_block;
      d.cpu_en    = (d.mode == MODE_RUN);
      d.osc_run   = (d.mode != MODE_PDOWN);
      d.periph_en = (d.mode != MODE_PDOWN)
                    | (EXTENDED & ((q.ca ^ COUNTER_A_I)
                                   | (q.cb ^ COUNTER_B_I)));
      if (d.pin) begin
         // Released to the pull-ups so outside logic cannot fight us
         d.ale      = 1'b1;
         d.ale_oe   = 1'b0;
         d.fetch_n  = 1'b1;
         d.fetch_oe = 1'b0;
      end else if (d.rseq == RSEQ_ACTIVE || d.rseq == RSEQ_RELEASE) begin
         d.ale      = 1'b1;
         d.ale_oe   = 1'b1;
         d.fetch_n  = 1'b1;
         d.fetch_oe = 1'b1;
      end else if (d.mode == MODE_IDLE) begin
         d.ale      = 1'b1;
         d.ale_oe   = 1'b1;
         d.fetch_n  = 1'b1;
         d.fetch_oe = 1'b1;
      end else if (d.mode == MODE_PDOWN) begin
         d.ale      = 1'b0;
         d.ale_oe   = 1'b1;
         d.fetch_n  = 1'b0;
         d.fetch_oe = 1'b1;
      end else begin
         d.ale      = ALE_HIGH_MASK[mc_idx];
         d.ale_oe   = 1'b1;
         d.fetch_n  = ~FETCH_LO_MASK[mc_idx];
         d.fetch_oe = 1'b1;
      end
   end

   // ---------------------------------------------------------------
   // State register
   // ---------------------------------------------------------------
   always_ff @(posedge CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         q           <= '0;
         q.hready    <= 1'b1;
         q.ale       <= 1'b1;
         q.fetch_n   <= 1'b1;
         q.port_ones <= 1'b1;
         q.osc_run   <= 1'b1;
         q.acc_ok    <= 1'b1;
         q.ca        <= 1'b1; // Pins idle high, no false edge
         q.cb        <= 1'b1;
      end else begin
         q <= d;
      end
   end

   // Outputs, all but HRESP_O from the state register
   assign HRDATA_O              = q.rdata;
   assign HREADYOUT_O           = q.hready;
   assign HRESP_O               = 1'b0;
   assign ADDR_LATCH_O          = q.ale;
   assign ADDR_LATCH_OE_O       = q.ale_oe;
   assign PROG_FETCH_STROBE_N_O = q.fetch_n;
   assign PROG_FETCH_OE_O       = q.fetch_oe;
   assign PORT_ONES_O           = q.port_ones;
   assign SFR_RESET_O           = q.sfr_rst;
   assign CPU_CLK_EN_O          = q.cpu_en;
   assign OSC_RUN_O             = q.osc_run;
   assign PERIPH_CLK_EN_O       = q.periph_en;
   assign WAKE_O                = q.wake;
   assign WAKE_VECTOR_O         = q.wake_vec;
   assign BAUD_DOUBLE_O         = q.pmc[BAUD_DOUBLE];
   assign INT_ACCEPT_OK_O       = q.acc_ok;

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   property p_rst_delay;
      @(posedge CLK_I) disable iff (!ARST_N_I)
      $rose(q.rseq == RSEQ_PEND) |-> ##19 (q.rseq == RSEQ_ACTIVE);
   endproperty
   a_rst_delay: assert property (p_rst_delay)
      else $error("reset took wrong number of periods");

   property p_weak_strobe;
      @(posedge CLK_I) disable iff (!ARST_N_I)
      q.pin |-> !ADDR_LATCH_OE_O && !PROG_FETCH_OE_O;
   endproperty
   a_weak_strobe: assert property (p_weak_strobe)
      else $error("strobe driven while reset pin high");

   property p_restart;
      @(posedge CLK_I) disable iff (!ARST_N_I)
      $rose(q.rseq == RSEQ_RELEASE) |-> ##[1:12] (q.rseq != RSEQ_RELEASE);
   endproperty
   a_restart: assert property (p_restart)
      else $error("strobes not restarted in time");

   property p_sfr_clear;
      @(posedge CLK_I) disable iff (!ARST_N_I)
      (q.rseq == RSEQ_ACTIVE) |=> (q.pmc == PMC_RESET)
                                  && (q.mode == MODE_RUN) && SFR_RESET_O;
   endproperty
   a_sfr_clear: assert property (p_sfr_clear)
      else $error("control register not cleared by reset");

   property p_port_ones;
      @(posedge CLK_I) disable iff (!ARST_N_I)
      $rose(RST_PIN_I) |=> PORT_ONES_O;
   endproperty
   a_port_ones: assert property (p_port_ones)
      else $error("ports not forced to ones");

   property p_idle_clocks;
      @(posedge CLK_I) disable iff (!ARST_N_I)
      (q.mode == MODE_IDLE) |-> !CPU_CLK_EN_O && OSC_RUN_O
                                && PERIPH_CLK_EN_O && ADDR_LATCH_O;
   endproperty
   a_idle_clocks: assert property (p_idle_clocks)
      else $error("idle clocking wrong");

   property p_idle_wake;
      @(posedge CLK_I) disable iff (!ARST_N_I)
      (q.mode == MODE_IDLE) && (q.rseq != RSEQ_ACTIVE) && req_en
      |=> (q.mode == MODE_RUN) && !q.pmc[SLEEP_CPU_BIT]
          && WAKE_O && WAKE_VECTOR_O;
   endproperty
   a_idle_wake: assert property (p_idle_wake)
      else $error("enabled request did not end idle");

   property p_idle_hold;
      @(posedge CLK_I) disable iff (!ARST_N_I)
      (q.mode == MODE_IDLE) && !req_any && (q.rseq != RSEQ_ACTIVE)
      |=> (q.mode == MODE_IDLE);
   endproperty
   a_idle_hold: assert property (p_idle_hold)
      else $error("idle left without cause");

   property p_pd_pins;
      @(posedge CLK_I) disable iff (!ARST_N_I)
      (q.mode == MODE_PDOWN) && (q.rseq == RSEQ_NORMAL) && !q.pin
      |-> !ADDR_LATCH_O && !PROG_FETCH_STROBE_N_O && !OSC_RUN_O;
   endproperty
   a_pd_pins: assert property (p_pd_pins)
      else $error("power-down pin state wrong");

   property p_return_from_service_op;
      @(posedge CLK_I) disable iff (!ARST_N_I)
      RETURN_FROM_SERVICE_OP_DONE_I && (q.rseq != RSEQ_ACTIVE) |=> !INT_ACCEPT_OK_O;
   endproperty
   a_return_from_service_op: assert property (p_return_from_service_op)
      else $error("request accepted right after return");

endmodule : rpm_top

// >>> sim/rpm_pin_model.sv
`timescale 1ns/1ps
module rpm_pin_model (
   input  wire logic clk_i,
   output logic      rst_pin_o,
   output logic      cnt_b_o
);
   // -----------------------------------------
   // Idle levels at power-up
   // -----------------------------------------
   initial begin
      rst_pin_o = 1'b0;
      cnt_b_o   = 1'b1;
   end

   // Reset source; too short a pulse is stretched, never trusted
   task automatic hold_reset(input int n);
      int k;
      k = (n < 24) ? 24 : n;
      @(posedge clk_i);
      rst_pin_o <= 1'b1;
      repeat (k) @(posedge clk_i);
      rst_pin_o <= 1'b0;
   endtask : hold_reset

   // Counter b pin; strobes are only watched, never pulled low
   task automatic set_cnt_b(input logic v);
      @(posedge clk_i);
      cnt_b_o <= v;
   endtask : set_cnt_b
endmodule : rpm_pin_model

// >>> sim/mcu_reset_and_power_modes_tb.sv
`timescale 1ns/1ps
module mcu_reset_and_power_modes_tb;
   import rpm_pkg::*;
   logic        clk, arst_n, hsel, hwrite, hrdy, hresp, rst_pin, cnt_b;
   logic        instr_end, return_from_service_op_done, ale, ale_oe, program_fetch_strobe_n, program_fetch_strobe_oe;
   logic        ports1, sfr_rst, cpu_en, osc_run, per_en, wake, wvec;
   logic        baud, acc_ok, cnt_a;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic [5:0]  int_req, int_en;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [3:0]  obs;
   int          errors, n_compared, pmc_m, seed, v;

   rpm_top DUT (.CLK_I(clk), .ARST_N_I(arst_n), .HSEL_I(hsel),
      .HADDR_I(haddr), .HTRANS_I(htrans), .HWRITE_I(hwrite),
      .HSIZE_I(hsize), .HWDATA_I(hwdata), .HREADY_I(hrdy),
      .HRDATA_O(hrdata), .HREADYOUT_O(hrdy), .HRESP_O(hresp),
      .RST_PIN_I(rst_pin), .INT_REQ_I(int_req), .INT_EN_I(int_en),
      .COUNTER_A_I(cnt_a), .COUNTER_B_I(cnt_b), .INSTR_END_I(instr_end),
      .RETURN_FROM_SERVICE_OP_DONE_I(return_from_service_op_done), .ADDR_LATCH_O(ale),
      .ADDR_LATCH_OE_O(ale_oe), .PROG_FETCH_STROBE_N_O(program_fetch_strobe_n),
      .PROG_FETCH_OE_O(program_fetch_strobe_oe), .PORT_ONES_O(ports1),
      .SFR_RESET_O(sfr_rst), .CPU_CLK_EN_O(cpu_en), .OSC_RUN_O(osc_run),
      .PERIPH_CLK_EN_O(per_en), .WAKE_O(wake), .WAKE_VECTOR_O(wvec),
      .BAUD_DOUBLE_O(baud), .INT_ACCEPT_OK_O(acc_ok));
   rpm_pin_model PM (.clk_i(clk), .rst_pin_o(rst_pin), .cnt_b_o(cnt_b));
   assign obs = {ale_oe, ~osc_run, sfr_rst, wake};

   // -----------------------------------------
   // Clock and hang guard
   // -----------------------------------------
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   initial begin
      repeat (20000) @(posedge clk);
      errors++;
      close_out();
   end

   // Verdict, printed in one place only
   task automatic close_out();
      $display("compared %0d mismatches %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : close_out

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         errors++;
         $display("MISMATCH %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk

   // Single AHB word transfer; waits only on hready, with a bound
   task automatic ahb(input logic w, input logic [31:0] a,
                      input logic [31:0] wd);
      int t;
      t = 0;
      @(posedge clk);
      htrans <= 2'b10;
      haddr  <= a;
      hwrite <= w;
      do @(posedge clk); while (hrdy !== 1'b1 && ++t < 50);
      htrans <= 2'b00;
      hwdata <= wd;
      do @(posedge clk); while (hrdy !== 1'b1 && ++t < 50);
      rd = hrdata;
      if (t >= 50) begin
         errors++;
         close_out();
      end
   endtask : ahb

   // Bounded wait on one watched output, returns cycles taken in v
   task automatic wait_for(input int s);
      v = 0;
      do begin
         @(negedge clk);
         v++;
      end while (obs[s] !== 1'b1 && v < 400);
      if (v >= 400) begin
         errors++;
         close_out();
      end
   endtask : wait_for

   task automatic pulse_end();
      @(posedge clk);
      instr_end <= 1'b1;
      @(posedge clk);
      instr_end <= 1'b0;
   endtask : pulse_end

   task automatic rd_pmc();
      ahb(1'b0, PMC_ADDR, 32'h0000_0000);
      chk(rd, pmc_m);
      chk(hresp, 1'b0);
   endtask : rd_pmc

   // Request wake and check the resume or vector choice
   task automatic wake_by(input logic [5:0] en, input logic exp_vec);
      @(posedge clk);
      int_en  <= en;
      int_req <= 6'h01;
      wait_for(0);
      chk(wvec, exp_vec);
      @(posedge clk);
      int_req <= 6'h00;
   endtask : wake_by

   // -----------------------------------------
   // Main sequence
   // -----------------------------------------
   initial begin
      seed = 20284;
      {hsel, hwrite, instr_end, return_from_service_op_done} = 4'h8;
      cnt_a = 1'b1;
      {htrans, hsize} = {2'b00, SIZE_WORD};
      {haddr, hwdata, int_req, int_en} = '0;
      arst_n = 1'b0;
      repeat (2) @(posedge clk);
      arst_n <= 1'b1;
      pmc_m = PMC_RESET;
      rd_pmc();
      ahb(1'b0, 32'h0000_0010, 32'h0000_0000);
      chk(rd, 32'h0000_0000);
      // Random flags; bits 0 and 1 masked so no mode is entered
      repeat (4) begin
         v = $random(seed) & 32'h0000_00FC;
         ahb(1'b1, PMC_ADDR, v);
         pmc_m = v & 32'h0000_00EC;
         rd_pmc();
         chk(baud, pmc_m[7]);
      end
      // Idle, woken by an enabled request
      pmc_m = 1;
      ahb(1'b1, PMC_ADDR, 32'h0000_0001);
      repeat (3) @(negedge clk);
      chk({cpu_en, osc_run, per_en}, 3'b011);
      chk({ale, program_fetch_strobe_n}, 2'b11);
      repeat (30) @(negedge clk);
      chk(cpu_en, 1'b0);
      // Status shows idle and nothing else pending
      ahb(1'b0, STATUS_ADDR, 32'h0000_0000);
      chk(rd, 32'h0000_0001);
      wake_by(6'h01, 1'b1);
      pmc_m = 0;
      rd_pmc();
      // Idle with wake-any, disabled request resumes
      pmc_m = 32'h20;
      ahb(1'b1, PMC_ADDR, 32'h0000_0021);
      repeat (3) @(negedge clk);
      wake_by(6'h00, 1'b0);
      // Software power-down, left by an enabled request
      ahb(1'b1, PMC_ADDR, 32'h0000_0002);
      wait_for(2);
      chk({ale, program_fetch_strobe_n, per_en}, 3'b000);
      // An edge on counter a still clocks the timers
      @(posedge clk);
      cnt_a <= 1'b0;
      @(posedge clk);
      @(negedge clk);
      chk(per_en, 1'b1);
      wake_by(6'h01, 1'b1);
      // Pin shutdown: falling edge arms, instruction end enters
      ahb(1'b1, PMC_ADDR, 32'h0000_0040);
      PM.set_cnt_b(1'b0);
      repeat (3) @(negedge clk);
      chk(osc_run, 1'b1);
      pulse_end();
      wait_for(2);
      @(posedge clk);
      int_en  <= 6'h3F;
      int_req <= 6'h3F;
      repeat (30) @(negedge clk);
      chk({osc_run, wake}, 2'b00);
      @(posedge clk);
      int_req <= 6'h00;
      PM.set_cnt_b(1'b1);
      wait_for(0);
      chk(wvec, 1'b0);
      // Return from service blocks acceptance until one more end
      @(posedge clk);
      return_from_service_op_done <= 1'b1;
      @(posedge clk);
      return_from_service_op_done <= 1'b0;
      @(negedge clk);
      chk(acc_ok, 1'b0);
      pulse_end();
      repeat (2) @(negedge clk);
      chk(acc_ok, 1'b1);
      // Pin reset out of idle
      ahb(1'b1, PMC_ADDR, 32'h0000_000D);
      fork
         PM.hold_reset(30);
      join_none
      repeat (3) @(negedge clk);
      chk({ports1, ale_oe, program_fetch_strobe_oe}, 3'b100);
      chk(sfr_rst, 1'b0);
      wait_for(1);
      chk(v >= 18 && v <= 34, 1'b1);
      wait_for(3);
      chk(v <= 40, 1'b1);
      chk(cpu_en, 1'b1);
      pmc_m = 0;
      rd_pmc();
      close_out();
   end
endmodule : mcu_reset_and_power_modes_tb
